// file: bench/ctrl_model.sv
/*
  controller model driving the sdram command core: commands and write
  beats changed at the falling edge, mode pins set once at time zero.
  assumes one core_clk and a bench that sequences the calls.
*/
`default_nettype none
module ctrl_model (
  input wire logic core_clk,
  output logic clkEn,
  output sdram_cmd_pkg::cmd_s cmdIn,
  output sdram_cmd_pkg::beat_s beatIn,
  output logic otfEnable,
  output logic modeBurstFull
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] NOP = 4'h7; // cs low, rest high

  // idle pins at time zero
  initial begin
    clkEn = 1'b1;
    cmdIn = {4'hf, 3'h0, 14'h0000};
    beatIn = '{1'b0, 8'h00, 1'b0};
    otfEnable = 1'b1; // a12 picks the burst length
    modeBurstFull = 1'b1;
  end

  // one command on the next edge; enable high for act, pre, ref, low for self refresh entry
  // bench only writes opened banks and activates idle ones
  // no write overlaps an auto precharge burst
  // refreshes sent one by one, never postponed
  // few refreshes, far under the window limit
  // reference never floats, so no write delay after exit
  task automatic send(input logic [3:0] code, input logic [2:0] b, input logic [13:0] a,
                      input logic ce);
    @(negedge core_clk);
    clkEn = ce;
    cmdIn = {code, b, a};
    beatIn.valid = 1'b0;
  endtask

  // no-operation slots, used for every wait after pre or ref
  task automatic idle(input int n, input logic [2:0] b, input logic [13:0] a, input logic ce);
    repeat (n) begin
      @(negedge core_clk);
      clkEn = ce;
      cmdIn = {NOP, b, a};
      beatIn.valid = 1'b0;
      beatIn.data = ~beatIn.data; // stale data never looks valid
    end
  endtask

  // write beats after a write; one beat may carry the mask
  task automatic burst(input int n, input logic [7:0] base, input int maskAt);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      cmdIn = {NOP, cmdIn.bank, ~cmdIn.addr};
      beatIn = '{1'b1, base + 8'(i), (i == maskAt)};
    end
    @(negedge core_clk);
    beatIn.valid = 1'b0;
    beatIn.data = ~beatIn.data;
  endtask
endmodule
`default_nettype wire

// file: bench/sdram_write_precharge_refresh_cmds_tb.sv
/*
  self-checking bench for the sdram command core: writes with mask,
  precharge forms, refresh and self refresh.
  assumes ctrl_model drives every input but core_clk and srst.
*/
`default_nettype none
module sdram_write_precharge_refresh_cmds_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] REF = 4'h1;
  logic core_clk = 1'b0;
  logic srst = 1'b1; // held for four edges
  logic clkEn;
  sdram_cmd_pkg::cmd_s cmdIn;
  sdram_cmd_pkg::beat_s beatIn;
  logic otfEnable;
  logic modeBurstFull;
  logic [7:0] bankOpen;
  logic [7:0] bankPrecharging;
  logic writeBusy;
  logic refreshBusy;
  logic selfRefresh;
  logic [7:0] refreshRow;
  logic [7:0] readData;
  int n_fail = 0;
  int n_checks = 0;

  // 25 MHz
  always #20 core_clk = ~core_clk;

  sdram_cmd_core i_sdram_cmd_core (.core_clk(core_clk), .srst(srst), .clkEn(clkEn),
    .cmdIn(cmdIn), .beatIn(beatIn), .otfEnable(otfEnable), .modeBurstFull(modeBurstFull),
    .bankOpen(bankOpen), .bankPrecharging(bankPrecharging), .writeBusy(writeBusy),
    .refreshBusy(refreshBusy), .selfRefresh(selfRefresh), .refreshRow(refreshRow),
    .readData(readData));
  ctrl_model i_ctrl_model (.core_clk(core_clk), .clkEn(clkEn), .cmdIn(cmdIn),
    .beatIn(beatIn), .otfEnable(otfEnable), .modeBurstFull(modeBurstFull));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // storage readout comes one edge after the nop that addresses it
  task automatic peek(input logic [2:0] b, input logic [2:0] col, input logic [7:0] exp);
    i_ctrl_model.idle(1, b, {11'h000, col}, 1'b1);
    @(negedge core_clk);
    check(32'(readData), 32'(exp), "stored byte");
  endtask

  // nop window, counting cycles with precharge of bank b or refresh busy;
  // sampled before each nop so a one-cycle span right after the command counts
  task automatic countHigh(input int n, input int b, output int kPre, output int kRef);
    kPre = 0;
    kRef = 0;
    repeat (n) begin
      kPre += int'(bankPrecharging[b]);
      kRef += int'(refreshBusy);
      i_ctrl_model.idle(1, 3'h0, 14'h0000, 1'b1);
    end
  endtask

  // full burst with auto precharge, length from a12
  task automatic t_write_ap();
    int kp;
    int kr;
    i_ctrl_model.send(ACT, 3'h3, 14'h0021, 1'b1);
    i_ctrl_model.send(WR, 3'h3, 14'h1400, 1'b1); // a12 and a10 high, column 0
    i_ctrl_model.burst(8, 8'h10, 99);
    countHigh(6, 3, kp, kr);
    check(32'(kp), 32'(sdram_cmd_pkg::ROW_PRECHARGE_CYC), "auto precharge span");
    check(32'(bankOpen), 32'h0000_0000, "row closed after burst");
    peek(3'h3, 3'h0, 8'h10);
    peek(3'h3, 3'h7, 8'h17);
  endtask

  // chop of four wrapping the column, one masked beat, row left open
  task automatic t_write_chop();
    i_ctrl_model.send(ACT, 3'h3, 14'h0021, 1'b1);
    i_ctrl_model.send(WR, 3'h3, 14'h0006, 1'b1);
    i_ctrl_model.burst(4, 8'ha0, 1);
    i_ctrl_model.idle(2, 3'h0, 14'h0000, 1'b1);
    check(32'(bankOpen), 32'h0000_0008, "row kept open");
    peek(3'h3, 3'h6, 8'ha0);
    peek(3'h3, 3'h7, 8'h17);
    peek(3'h3, 3'h0, 8'ha2);
    peek(3'h3, 3'h1, 8'ha3);
    peek(3'h3, 3'h2, 8'h12);
  endtask

  // deselected write, single, idle and all-bank precharge
  task automatic t_precharge();
    int kp;
    int kr;
    i_ctrl_model.send({1'b1, WR[2:0]}, 3'h3, 14'h0000, 1'b1);
    @(negedge core_clk);
    check(32'(writeBusy), 32'h0000_0000, "deselect ignored");
    i_ctrl_model.send(ACT, 3'h1, 14'h0005, 1'b1);
    i_ctrl_model.send(PRE, 3'h3, 14'h0000, 1'b1);
    i_ctrl_model.idle(2, 3'h0, 14'h0000, 1'b1);
    check(32'(bankOpen), 32'h0000_0002, "one bank closed");
    i_ctrl_model.send(PRE, 3'h5, 14'h0000, 1'b1);
    countHigh(4, 5, kp, kr);
    check(32'(kp), 32'h0000_0000, "idle bank untouched");
    i_ctrl_model.send(ACT, 3'h2, 14'h0005, 1'b1);
    i_ctrl_model.send(PRE, 3'h5, 14'h0400, 1'b1); // bank field ignored
    i_ctrl_model.idle(3, 3'h0, 14'h0000, 1'b1);
    check(32'(bankOpen), 32'h0000_0000, "all banks closed");
    check(32'(writeBusy), 32'h0000_0000, "nop registers nothing");
  endtask

  // refresh busy span and internal row, address pins ignored
  task automatic t_refresh();
    int kp;
    int kr;
    logic [7:0] row0;
    row0 = refreshRow;
    i_ctrl_model.send(REF, 3'h7, 14'h3fff, 1'b1);
    countHigh(8, 0, kp, kr);
    check(32'(kr), 32'(sdram_cmd_pkg::REFRESH_CYCLE_CYC), "refresh span");
    check(32'(refreshRow), 32'(row0 + 8'h01), "internal row step");
  endtask

  // self refresh entry, hold, exit and data kept
  task automatic t_self();
    i_ctrl_model.send(REF, 3'h0, 14'h0000, 1'b0);
    i_ctrl_model.idle(3, 3'h0, 14'h0000, 1'b0);
    check(32'(selfRefresh), 32'h0000_0001, "self refresh entered");
    i_ctrl_model.idle(3, 3'h0, 14'h0000, 1'b1);
    check(32'(selfRefresh), 32'h0000_0000, "self refresh left");
    peek(3'h3, 3'h6, 8'ha0);
  endtask

  // watchdog, far beyond the expected run
  initial begin
    #(40 * 3000);
    n_fail++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    check(32'({bankOpen, bankPrecharging, writeBusy, refreshBusy, selfRefresh}),
          32'h0000_0000, "reset state");
    t_write_ap();
    t_write_chop();
    t_precharge();
    t_refresh();
    t_self();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: inc/sdram_cmd_pkg.sv
/*
  shared constants and carriers for the sdram command core: command
  encodings, burst lengths, timing counts and the packed command and
  write-beat structs.
  assumes a single 25 MHz core clock and synchronous command inputs.
*/
`default_nettype none
package sdram_cmd_pkg;
  // clock figures
  localparam int CLK_PERIOD_NS = 40;
  // precharge and refresh cycle times (plain defaults)
  localparam int ROW_PRECHARGE_NS = 15;
  localparam int REFRESH_CYCLE_NS = 160;
  // least times round up to whole cycles
  localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // self refresh internal row period, default shortened for simulation
  localparam int SELF_ROW_PERIOD = 64;
  // burst lengths
  localparam int BURST_CHOP = 4;
  localparam int BURST_FULL = 8;
  // address bit positions
  localparam int AP_BIT = 10;
  localparam int OTF_BIT = 12;
  // after reset
  localparam logic [3:0] TIMER_ZERO = 4'h0;

  // decoded command kinds
  typedef enum {
    CMD_NONE, CMD_WRITE, CMD_PRECHARGE, CMD_REFRESH, CMD_SELF_ENTER, CMD_OTHER
  } cmd_e;

  // one command slot as sampled on a rising edge
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [2:0] bank;
    logic [13:0] addr;
  } cmd_s;

  // one write data beat with its mask
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic mask;
  } beat_s;
endpackage
`default_nettype wire

// file: rtl/sdram_cmd_core.sv
/*
  command core of the sdram: write with mask and auto precharge,
  per-bank and all-bank precharge with restartable timing, refresh with
  internal row counter, and self refresh entry and exit.
  assumes the controller keeps its own timing; inputs are synchronous
  to core_clk; memory is a small flop array indexed by bank and column.
*/
`default_nettype none
// How it works
// - write bursts only into an opened row
// - write bank taken from bank inputs
// - a10 on write requests auto precharge
// - a12 picks chop four or eight
// - masked beats leave storage unchanged
// - precharge one bank, or all on a10
// - precharge of idle bank is a no-op
// - precharge timing restarts on last command
// - refresh uses internal row, ignores address
// - self refresh keeps data without clock
// - deselect accepts no new command
// - nop registers no command
module sdram_cmd_core #(
  parameter int BANKS = 8,
  parameter int COLS = 8,
  parameter int ROW_BITS = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire sdram_cmd_pkg::cmd_s cmdIn,
  input wire sdram_cmd_pkg::beat_s beatIn,
  input wire logic otfEnable,
  input wire logic modeBurstFull,
  output logic [BANKS-1:0] bankOpen,
  output logic [BANKS-1:0] bankPrecharging,
  output logic writeBusy,
  output logic refreshBusy,
  output logic selfRefresh,
  output logic [ROW_BITS-1:0] refreshRow,
  output logic [7:0] readData
);
  initial begin
    if (BANKS != 8 || COLS < 8 || ROW_BITS < 1) begin
      $error("sdram_cmd_core: unsupported parameters");
    end
  end

  localparam int CB = $clog2(COLS);
  localparam int BB = $clog2(BANKS);

  // command decode, shared by the bank and refresh next-state blocks
  function automatic sdram_cmd_pkg::cmd_e decode(input sdram_cmd_pkg::cmd_s c,
                                                  input logic cePrev, input logic ceNow);
    if (c.csN) begin
      decode = sdram_cmd_pkg::CMD_NONE; // deselect
    end else if (!cePrev) begin
      decode = sdram_cmd_pkg::CMD_NONE;
    end else begin
      case ({c.rasN, c.casN, c.weN})
        3'b111: decode = sdram_cmd_pkg::CMD_NONE; // nop
        3'b100: decode = ceNow ? sdram_cmd_pkg::CMD_WRITE : sdram_cmd_pkg::CMD_OTHER;
        3'b010: decode = sdram_cmd_pkg::CMD_PRECHARGE;
        3'b001: decode = ceNow ? sdram_cmd_pkg::CMD_REFRESH : sdram_cmd_pkg::CMD_SELF_ENTER;
        default: decode = sdram_cmd_pkg::CMD_OTHER;
      endcase
    end
  endfunction

  logic cePrev; // clock enable at previous edge
  sdram_cmd_pkg::cmd_e cmd;
  always_comb begin
    cmd = decode(cmdIn, cePrev, clkEn);
  end
  wire activateCmd = !cmdIn.csN && cePrev && clkEn &&
                     ({cmdIn.rasN, cmdIn.casN, cmdIn.weN} == 3'b011);

  // bank state
  logic [BANKS-1:0] next_bankOpen, next_bankPrecharging;
  logic [3:0] pcTimer [BANKS];
  logic [3:0] next_pcTimer [BANKS];
  logic [BANKS-1:0] apPending, next_apPending; // auto precharge after burst
  // write burst state
  logic writeActive, next_writeActive;
  logic [BB-1:0] wrBank, next_wrBank;
  logic [CB-1:0] wrCol, next_wrCol;
  logic [3:0] beatsLeft, next_beatsLeft;
  logic wrAuto, next_wrAuto;
  // refresh state
  logic [3:0] rfTimer, next_rfTimer;
  logic [ROW_BITS-1:0] next_refreshRow;
  logic next_selfRefresh;
  logic [7:0] selfTick, next_selfTick;
  // storage
  logic [7:0] mem [BANKS*COLS];
  logic [7:0] next_readData;
  logic endBurst;

  // bank, precharge and burst next-state
  always_comb begin
    next_bankOpen = bankOpen;
    next_bankPrecharging = bankPrecharging;
    next_apPending = apPending;
    next_pcTimer = pcTimer;
    next_writeActive = writeActive;
    next_wrBank = wrBank;
    next_wrCol = wrCol;
    next_beatsLeft = beatsLeft;
    next_wrAuto = wrAuto;
    endBurst = writeActive && beatIn.valid && (beatsLeft == 4'h1);
    // count down running precharges
    for (int b = 0; b < BANKS; b++) begin
      if (bankPrecharging[b]) begin
        if (pcTimer[b] <= 4'h1) begin
          next_bankPrecharging[b] = 1'b0; // bank now idle
          next_pcTimer[b] = sdram_cmd_pkg::TIMER_ZERO;
        end else begin
          next_pcTimer[b] = pcTimer[b] - 4'h1;
        end
      end
    end
    // burst beats
    if (writeActive && beatIn.valid) begin
      next_wrCol = wrCol + CB'(1);
      next_beatsLeft = beatsLeft - 4'h1;
      if (endBurst) begin
        next_writeActive = 1'b0;
        if (wrAuto) begin // close row after burst
          next_bankOpen[wrBank] = 1'b0;
          next_bankPrecharging[wrBank] = 1'b1;
          next_pcTimer[wrBank] = 4'(sdram_cmd_pkg::ROW_PRECHARGE_CYC);
          next_apPending[wrBank] = 1'b0;
        end
      end
    end
    case (cmd)
      sdram_cmd_pkg::CMD_WRITE: begin
        // only an open bank accepts a burst
        if (bankOpen[cmdIn.bank] && !writeActive) begin
          next_writeActive = 1'b1;
          next_wrBank = cmdIn.bank;
          next_wrCol = cmdIn.addr[CB-1:0];
          next_wrAuto = cmdIn.addr[sdram_cmd_pkg::AP_BIT];
          next_apPending[cmdIn.bank] = cmdIn.addr[sdram_cmd_pkg::AP_BIT];
          // on-the-fly chop or fixed mode length
          if (otfEnable) begin
            next_beatsLeft = cmdIn.addr[sdram_cmd_pkg::OTF_BIT] ?
                             4'(sdram_cmd_pkg::BURST_FULL) : 4'(sdram_cmd_pkg::BURST_CHOP);
          end else begin
            next_beatsLeft = modeBurstFull ?
                             4'(sdram_cmd_pkg::BURST_FULL) : 4'(sdram_cmd_pkg::BURST_CHOP);
          end
        end
      end
      sdram_cmd_pkg::CMD_PRECHARGE: begin
        for (int b = 0; b < BANKS; b++) begin
          // all banks on a10, else the addressed one
          if (cmdIn.addr[sdram_cmd_pkg::AP_BIT] || cmdIn.bank == BB'(b)) begin
            if (bankOpen[b] || bankPrecharging[b]) begin
              next_bankOpen[b] = 1'b0;
              next_bankPrecharging[b] = 1'b1;
              // restart from the latest command
              next_pcTimer[b] = 4'(sdram_cmd_pkg::ROW_PRECHARGE_CYC);
            end
            // idle bank: nothing happens
          end
        end
      end
      default: begin
        if (activateCmd && !bankPrecharging[cmdIn.bank]) begin
          next_bankOpen[cmdIn.bank] = 1'b1;
        end
      end
    endcase
  end

  // refresh and self refresh next-state
  always_comb begin
    next_rfTimer = rfTimer;
    next_refreshRow = refreshRow;
    next_selfRefresh = selfRefresh;
    next_selfTick = selfTick;
    if (rfTimer != sdram_cmd_pkg::TIMER_ZERO) begin
      next_rfTimer = rfTimer - 4'h1;
    end
    if (selfRefresh) begin
      // internal refresh without external commands
      next_selfTick = selfTick + 8'h01;
      if (selfTick == 8'(sdram_cmd_pkg::SELF_ROW_PERIOD - 1)) begin
        next_selfTick = 8'h00;
        next_refreshRow = refreshRow + ROW_BITS'(1);
      end
      // exit on clock enable rising, whatever command is on the inputs
      if (clkEn && !cePrev) begin
        next_selfRefresh = 1'b0;
      end
    end else if (cmd == sdram_cmd_pkg::CMD_REFRESH) begin
      // internal row, address ignored
      next_refreshRow = refreshRow + ROW_BITS'(1);
      next_rfTimer = 4'(sdram_cmd_pkg::REFRESH_CYCLE_CYC);
    end else if (cmd == sdram_cmd_pkg::CMD_SELF_ENTER) begin
      next_selfRefresh = 1'b1;
      next_selfTick = 8'h00;
    end
  end

  // read-back of the bank and column on the command inputs for visibility
  always_comb begin
    next_readData = mem[{cmdIn.bank, cmdIn.addr[CB-1:0]}];
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cePrev <= 1'b0;
      bankOpen <= '0;
      bankPrecharging <= '0;
      apPending <= '0;
      for (int b = 0; b < BANKS; b++) begin
        pcTimer[b] <= sdram_cmd_pkg::TIMER_ZERO;
      end
      writeActive <= 1'b0;
      wrBank <= '0;
      wrCol <= '0;
      beatsLeft <= sdram_cmd_pkg::TIMER_ZERO;
      wrAuto <= 1'b0;
      rfTimer <= sdram_cmd_pkg::TIMER_ZERO;
      refreshRow <= '0;
      selfRefresh <= 1'b0;
      selfTick <= 8'h00;
      readData <= 8'h00;
      refreshBusy <= 1'b0;
    end else begin
      cePrev <= clkEn;
      bankOpen <= next_bankOpen;
      bankPrecharging <= next_bankPrecharging;
      apPending <= next_apPending;
      pcTimer <= next_pcTimer;
      writeActive <= next_writeActive;
      wrBank <= next_wrBank;
      wrCol <= next_wrCol;
      beatsLeft <= next_beatsLeft;
      wrAuto <= next_wrAuto;
      rfTimer <= next_rfTimer;
      refreshRow <= next_refreshRow;
      selfRefresh <= next_selfRefresh;
      selfTick <= next_selfTick;
      readData <= next_readData;
      // registered so the pin never glitches on the timer decode
      refreshBusy <= (next_rfTimer != sdram_cmd_pkg::TIMER_ZERO);
    end
  end

  // storage has no reset: contents survive self refresh
  always_ff @(posedge core_clk) begin
    if (writeActive && beatIn.valid && !beatIn.mask) begin
      mem[{wrBank, wrCol}] <= beatIn.data; // masked beat skipped
    end
  end

  assign writeBusy = writeActive;

  // write to a closed bank never starts a burst
  property p_write_needs_open;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_WRITE && !bankOpen[cmdIn.bank] && !writeActive)
      |=> !writeActive;
  endproperty
  a_write_needs_open: assert property (p_write_needs_open)
    else $error("write started on closed bank");

  property p_write_bank;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_WRITE && bankOpen[cmdIn.bank] && !writeActive)
      |=> wrBank == $past(cmdIn.bank);
  endproperty
  a_write_bank: assert property (p_write_bank)
    else $error("write bank not taken from inputs");

  property p_auto_close;
    @(posedge core_clk) disable iff (srst)
      (endBurst && wrAuto) |=> !bankOpen[$past(wrBank)] && bankPrecharging[$past(wrBank)];
  endproperty
  a_auto_close: assert property (p_auto_close)
    else $error("auto precharge did not close row");

  property p_otf_len;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_WRITE && bankOpen[cmdIn.bank] && !writeActive && otfEnable)
      |=> beatsLeft == ($past(cmdIn.addr[12]) ? 4'h8 : 4'h4);
  endproperty
  a_otf_len: assert property (p_otf_len)
    else $error("burst length not chosen by a12");

  property p_mask_keeps;
    @(posedge core_clk) disable iff (srst)
      (writeActive && beatIn.valid && beatIn.mask) |=>
        mem[$past({wrBank, wrCol})] == $past(mem[{wrBank, wrCol}]);
  endproperty
  a_mask_keeps: assert property (p_mask_keeps)
    else $error("masked beat changed storage");

  property p_pre_all;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_PRECHARGE && cmdIn.addr[10]) |=> bankOpen == '0;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("all-bank precharge left a row open");

  property p_pre_idle_nop;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_PRECHARGE && !cmdIn.addr[10] && !writeActive &&
       !bankOpen[cmdIn.bank] && !bankPrecharging[cmdIn.bank])
      |=> !bankPrecharging[$past(cmdIn.bank)];
  endproperty
  a_pre_idle_nop: assert property (p_pre_idle_nop)
    else $error("precharge of idle bank not ignored");

  property p_pre_restart;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_PRECHARGE && !cmdIn.addr[10] && bankPrecharging[cmdIn.bank])
      |=> pcTimer[$past(cmdIn.bank)] == 4'(sdram_cmd_pkg::ROW_PRECHARGE_CYC);
  endproperty
  a_pre_restart: assert property (p_pre_restart)
    else $error("precharge time not restarted");

  property p_refresh_row;
    @(posedge core_clk) disable iff (srst)
      (cmd == sdram_cmd_pkg::CMD_REFRESH && !selfRefresh)
      |=> refreshRow == $past(refreshRow) + ROW_BITS'(1);
  endproperty
  a_refresh_row: assert property (p_refresh_row)
    else $error("refresh row not advanced internally");

  property p_deselect_quiet;
    @(posedge core_clk) disable iff (srst)
      (cmdIn.csN && !writeActive && !selfRefresh && bankPrecharging == '0)
      |=> bankOpen == $past(bankOpen) && !selfRefresh;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet)
    else $error("deselect changed bank state");
endmodule
`default_nettype wire
